// >>> rtl/lpm_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and byte addresses on the bus
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
`define LPM_ADR_IOCTL   4'h0
`define LPM_ADR_CPUCTL  4'h4
`define LPM_ADR_IRQEN   4'h8
`define LPM_ADR_STATUS  4'hC
`define LPM_FREEZE_BIT  5
`define LPM_CCR_B3      3
`define LPM_CCR_B6      6
`define LPM_IEF_BIT     7
`define LPM_IOCTL_RST   8'h00
`define LPM_CPUCTL_RST  8'h00
`define LPM_IRQEN_RST   8'h00
// restart time in tenths of a clock period
`define LPM_WAKE_X10    15
`define LPM_WAKE_CYC    ((`LPM_WAKE_X10 + 9) / 10)
`endif

// >>> rtl/lpm_pkg.sv
// types shared by the low power mode controller
// assumes nothing beyond the system clock domain
`default_nettype none
package lpm_pkg;
    typedef enum logic [4:0] {
        ST_NORMAL = 5'h01,
        ST_HALT   = 5'h02,
        ST_SLEEP  = 5'h04,
        ST_STOP   = 5'h08,
        ST_WAKE   = 5'h10
    } mode_e;
    typedef struct packed {
        mode_e       mode;
        logic [1:0]  cnt;
        logic        svc;
        logic [7:0]  ioctl;
        logic [7:0]  cpuctl;
        logic [7:0]  irqen;
        logic [15:0] ret;
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [3:0]  lvl;
        logic        ack;
        logic [31:0] dat;
        logic        halt_n;
        logic        strobe;
        logic        m1_n;
        logic        bus_high;
        logic        core_en;
        logic        dma_en;
        logic        per_en;
        logic        rfsh_en;
        logic        take;
        logic        resume;
    } lpm_state_s;
endpackage
`default_nettype wire

// >>> rtl/low_power_mode_control.sv
// halt, sleep, peripheral freeze and full-stop control with wishbone regs
// assumes core pulses for halt/sleep/ei/di and irq pins from outside
//
// Function
// - after halt, fetch only; halt, strobe and fetch-cycle pins low
// - halt keeps clocks, interrupts, grants, refresh and all peripherals
// - halt exits on reset, nmi, enabled on-chip or external interrupt
// - return address after halt is the following instruction
// - sleep entered when freeze bit and control bits 3 and 6 are zero
// - sleep gates core and dma clocks, stops refresh, keeps interrupts
// - sleep holds address and controls high, halt low, unless granted
// - peripherals keep running in sleep, only dma stops
// - sleep wakes on reset, nmi, enabled interrupts; disabled ones cannot
// - wake with global flag set services interrupt, returns after sleep
// - wake without nmi and with global flag clear just continues after sleep
// - core resumes about one and a half clocks after wake
// - freeze bit stops serial, clocked serial and timers; clear restarts
// - sleep with freeze set enters full-stop; clock output keeps running
// - full-stop exits like sleep but frozen peripherals cannot wake
// - normal operation keeps the halt indicator high
`default_nettype none
`include "lpm_cfg.svh"
module low_power_mode_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        halt_instr_i,
    input  wire logic        sleep_instr_i,
    input  wire logic        enable_irq_instr_i,
    input  wire logic        disable_irq_instr_i,
    input  wire logic [15:0] next_pc_i,
    input  wire logic        nmi_n_i,
    input  wire logic        ext_irq0_n_i,
    input  wire logic        ext_irq1_n_i,
    input  wire logic        ext_irq2_n_i,
    input  wire logic        periph_irq_i,
    input  wire logic        onchip_irq_i,
    input  wire logic        busack_i,
    output logic             halt_n_o,
    output logic             status_strobe_o,
    output logic             opcode_fetch_cycle_n_o,
    output logic             bus_high_o,
    output logic             core_clk_en_o,
    output logic             dma_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             refresh_en_o,
    output logic             irq_take_o,
    output logic             resume_o,
    output logic      [15:0] return_addr_o
);
    localparam logic [1:0] WAKE_LAST = 2'(`LPM_WAKE_CYC - 1);

    lpm_pkg::lpm_state_s q, d;
    logic                freeze, sleep_ok, nmi, ext_any, wake, halt_wake;
    logic                global_irq_enable_flag, acc, wr;
    lpm_pkg::mode_e      m;

    always_comb begin
        freeze   = q.ioctl[`LPM_FREEZE_BIT];
        global_irq_enable_flag      = q.irqen[`LPM_IEF_BIT];
        nmi      = ~q.lvl[3];
        ext_any  = |(~q.lvl[2:0] & q.irqen[2:0]);
        // frozen peripherals cannot raise a wake in full-stop
        wake     = nmi | ext_any | (onchip_irq_i & q.irqen[4])
                 | (periph_irq_i & q.irqen[3]
                    & (q.mode != lpm_pkg::ST_STOP));
        // a maskable request is only accepted out of halt when ief is set
        halt_wake = nmi | (global_irq_enable_flag & (wake & ~nmi));
        sleep_ok = ~q.cpuctl[`LPM_CCR_B3] & ~q.cpuctl[`LPM_CCR_B6];
        acc      = wb_cyc_i & wb_stb_i & ~q.ack;
        wr       = acc & wb_we_i & wb_sel_i[0];
    end

    always_comb begin
        d        = q;
        d.take   = 1'b0;
        d.resume = 1'b0;
        // pin synchroniser; a level counts once stages two and three agree
        d.s1 = {nmi_n_i, ext_irq2_n_i, ext_irq1_n_i, ext_irq0_n_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 4; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
        // bus slave: ack one cycle after the request, write on that edge
        d.ack = acc;
        d.dat = 32'h0000_0000;
        if (wr && wb_adr_i == `LPM_ADR_IOCTL) begin
            d.ioctl = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == `LPM_ADR_CPUCTL) begin
            d.cpuctl = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == `LPM_ADR_IRQEN) begin
            d.irqen = wb_dat_i[7:0];
        end
        // instruction flag changes win over a same-cycle register write
        if (enable_irq_instr_i) begin
            d.irqen[`LPM_IEF_BIT] = 1'b1;
        end else if (disable_irq_instr_i) begin
            d.irqen[`LPM_IEF_BIT] = 1'b0;
        end
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                `LPM_ADR_IOCTL:  d.dat = {24'h00_0000, q.ioctl};
                `LPM_ADR_CPUCTL: d.dat = {24'h00_0000, q.cpuctl};
                `LPM_ADR_IRQEN:  d.dat = {24'h00_0000, q.irqen};
                `LPM_ADR_STATUS: d.dat = {q.ret, 4'h0, q.lvl,
                                          3'h0, q.mode};
                default:         d.dat = 32'h0000_0000;
            endcase
        end
        case (q.mode)
            lpm_pkg::ST_NORMAL: begin
                if (halt_instr_i) begin
                    d.mode = lpm_pkg::ST_HALT;
                    d.ret  = next_pc_i;
                end else if (sleep_instr_i && sleep_ok) begin
                    d.ret  = next_pc_i;
                    if (freeze) begin
                        d.mode = lpm_pkg::ST_STOP;
                    end else begin
                        d.mode = lpm_pkg::ST_SLEEP;
                    end
                end
            end
            lpm_pkg::ST_HALT: begin
                if (halt_wake) begin
                    d.mode = lpm_pkg::ST_NORMAL;
                    d.take = 1'b1;
                    d.resume = 1'b1;
                end
            end
            lpm_pkg::ST_SLEEP, lpm_pkg::ST_STOP: begin
                if (wake) begin
                    d.mode = lpm_pkg::ST_WAKE;
                    d.cnt  = WAKE_LAST;
                    d.svc  = nmi | global_irq_enable_flag;
                end
            end
            lpm_pkg::ST_WAKE: begin
                if (q.cnt == 2'd0) begin
                    d.mode   = lpm_pkg::ST_NORMAL;
                    d.take   = q.svc;
                    d.resume = 1'b1;
                end else begin
                    d.cnt = q.cnt - 2'd1;
                end
            end
            default: d.mode = lpm_pkg::ST_NORMAL;
        endcase
        m = d.mode;
        d.halt_n   = (m == lpm_pkg::ST_NORMAL);
        d.strobe   = (m != lpm_pkg::ST_HALT);
        d.m1_n     = (m != lpm_pkg::ST_HALT);
        d.bus_high = (m == lpm_pkg::ST_SLEEP || m == lpm_pkg::ST_STOP
                      || m == lpm_pkg::ST_WAKE) && !busack_i;
        d.core_en  = (m == lpm_pkg::ST_NORMAL || m == lpm_pkg::ST_HALT);
        d.dma_en   = d.core_en;
        d.rfsh_en  = d.core_en;
        // clock output itself is never gated here, even in full-stop
        d.per_en   = ~d.ioctl[`LPM_FREEZE_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q        <= '0;
            q.mode   <= lpm_pkg::ST_NORMAL;
            q.ioctl  <= `LPM_IOCTL_RST;
            q.cpuctl <= `LPM_CPUCTL_RST;
            q.irqen  <= `LPM_IRQEN_RST;
            q.s1     <= 4'hF;
            q.s2     <= 4'hF;
            q.s3     <= 4'hF;
            q.lvl    <= 4'hF;
            q.halt_n <= 1'b1;
            q.strobe <= 1'b1;
            q.m1_n   <= 1'b1;
            q.core_en <= 1'b1;
            q.dma_en <= 1'b1;
            q.rfsh_en <= 1'b1;
            q.per_en <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o               = q.dat;
    assign wb_ack_o               = q.ack;
    assign halt_n_o               = q.halt_n;
    assign status_strobe_o        = q.strobe;
    assign opcode_fetch_cycle_n_o = q.m1_n;
    assign bus_high_o             = q.bus_high;
    assign core_clk_en_o          = q.core_en;
    assign dma_clk_en_o           = q.dma_en;
    assign periph_clk_en_o        = q.per_en;
    assign refresh_en_o           = q.rfsh_en;
    assign irq_take_o             = q.take;
    assign resume_o               = q.resume;
    assign return_addr_o          = q.ret;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_halt_pins: assert property (q.mode == lpm_pkg::ST_HALT |->
        !halt_n_o && !status_strobe_o && !opcode_fetch_cycle_n_o)
        else $error("halt pins not low");
    a_halt_clocks: assert property (q.mode == lpm_pkg::ST_HALT |->
        core_clk_en_o && dma_clk_en_o && refresh_en_o)
        else $error("halt stopped a clock");
    a_halt_exit: assert property (q.mode == lpm_pkg::ST_HALT && nmi
        |=> q.mode == lpm_pkg::ST_NORMAL && irq_take_o)
        else $error("halt did not exit on nmi");
    a_halt_ret: assert property (q.mode == lpm_pkg::ST_NORMAL
        && halt_instr_i |=> return_addr_o == $past(next_pc_i))
        else $error("return address wrong");
    a_sleep_entry: assert property (q.mode == lpm_pkg::ST_NORMAL
        && sleep_instr_i && !halt_instr_i && sleep_ok && !freeze
        |=> q.mode == lpm_pkg::ST_SLEEP)
        else $error("sleep not entered");
    a_sleep_gate: assert property (q.mode == lpm_pkg::ST_SLEEP |->
        !core_clk_en_o && !dma_clk_en_o && !refresh_en_o)
        else $error("sleep clocks not gated");
    a_sleep_bus: assert property (q.mode == lpm_pkg::ST_SLEEP
        && !$past(busack_i) |-> bus_high_o && !halt_n_o)
        else $error("sleep bus not held high");
    a_wake_delay: assert property (q.mode == lpm_pkg::ST_SLEEP && wake
        |=> q.mode == lpm_pkg::ST_WAKE [*2]
        ##1 q.mode == lpm_pkg::ST_NORMAL && resume_o)
        else $error("wake delay wrong");
    a_no_service: assert property (q.mode == lpm_pkg::ST_WAKE && !q.svc
        |-> ##[1:2] resume_o && !irq_take_o)
        else $error("interrupt taken with flag clear");
    a_freeze_clk: assert property (periph_clk_en_o == !freeze)
        else $error("peripherals not frozen");
    a_stop_mask: assert property (q.mode == lpm_pkg::ST_STOP && !nmi
        && !ext_any && !onchip_irq_i |=> q.mode == lpm_pkg::ST_STOP)
        else $error("frozen source woke full-stop");
    a_normal_halt: assert property (q.mode == lpm_pkg::ST_NORMAL |->
        halt_n_o)
        else $error("halt indicator low in normal");

    c_halt_exit: cover property (q.mode == lpm_pkg::ST_HALT ##1
        q.mode == lpm_pkg::ST_NORMAL);
    c_sleep_wake: cover property (q.mode == lpm_pkg::ST_WAKE ##1
        irq_take_o);
    c_stop: cover property (q.mode == lpm_pkg::ST_STOP);
    c_silent: cover property (resume_o && !irq_take_o);
endmodule
`default_nettype wire

// >>> tb/core_model.sv
// core side model: turns bench requests into one-cycle instruction pulses
// assumes one request per cycle; pc advances with every issued instruction
`default_nettype none
module core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        halt_req_i,
    input  wire logic        sleep_req_i,
    output logic             halt_instr_o,
    output logic             sleep_instr_o,
    output logic      [15:0] next_pc_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_i) begin
        halt_instr_o  <= halt_req_i & ~rst_i;
        sleep_instr_o <= sleep_req_i & ~rst_i;
        if (rst_i)
            next_pc_o <= 16'h1000;
        else if (halt_req_i | sleep_req_i)
            next_pc_o <= next_pc_o + 16'h0001;
    end
endmodule
`default_nettype wire

// >>> tb/low_power_mode_control_test.sv
// testbench for the low power mode controller
// assumes the core model issues instructions one cycle after a request
`default_nettype none
module low_power_mode_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc, stb, we, ack, hreq, sreq, ei, di;
    logic        nmi_n, irq0_n, irq1_n, irq2_n, pirq, oirq, busack;
    logic        hinst, sinst, halt_n, strb, m1_n, bus_high, core_en;
    logic        dma_en, per_en, rf_en, take, resume;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [15:0] npc, raddr, pc;
    int          num_errors, checks_done;
    core_model cm (.clk_i, .rst_i, .halt_req_i(hreq), .sleep_req_i(sreq),
        .halt_instr_o(hinst), .sleep_instr_o(sinst), .next_pc_o(npc));
    low_power_mode_control dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .halt_instr_i(hinst), .sleep_instr_i(sinst),
        .enable_irq_instr_i(ei), .disable_irq_instr_i(di),
        .next_pc_i(npc), .nmi_n_i(nmi_n), .ext_irq0_n_i(irq0_n),
        .ext_irq1_n_i(irq1_n), .ext_irq2_n_i(irq2_n), .periph_irq_i(pirq),
        .onchip_irq_i(oirq), .busack_i(busack), .halt_n_o(halt_n),
        .status_strobe_o(strb), .opcode_fetch_cycle_n_o(m1_n),
        .bus_high_o(bus_high), .core_clk_en_o(core_en),
        .dma_clk_en_o(dma_en), .periph_clk_en_o(per_en),
        .refresh_en_o(rf_en), .irq_take_o(take), .resume_o(resume),
        .return_addr_o(raddr));
    task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic instr(logic h);
        {hreq, sreq} <= {h, ~h};
        @(posedge clk_i) {hreq, sreq} <= 2'b00;
        pc = pc + 16'h0001;
        tick(3);
    endtask
    // bounded so a missing wake shows up as a failed check, not a hang
    task automatic wait_resume(output int n);
        n = 0;
        @(posedge clk_i);
        while (resume !== 1'b1 && n < 30) begin
            n++;
            @(posedge clk_i);
        end
        chk("resume", resume, 1'h1);
    endtask
    task automatic t_reset();
        chk("halt_n", halt_n, 1'h1);
        for (int i = 0; i < 3; i++) begin
            wb(1'b0, 4'(4 * i), 32'h0000_0000);
            chk("reg reset", q, 32'h0000_0000);
        end
        wb(1'b0, 4'hC, 32'h0000_0000);
        chk("status", q, 32'h0000_0F01);
        wb(1'b0, 4'h1, 32'h0000_0000);
        chk("unmapped", q, 32'h0000_0000);
    endtask
    task automatic t_halt();
        int n;
        instr(1'b1);
        chk("halt pins", {halt_n, strb, m1_n}, 3'h0);
        chk("halt enables", {core_en, dma_en, rf_en, per_en}, 4'hF);
        nmi_n <= 1'b0;
        wait_resume(n);
        chk("halt take", take, 1'h1);
        chk("halt ret", raddr, pc);
        @(posedge clk_i) nmi_n <= 1'b1;
        tick(6);
        chk("normal halt_n", halt_n, 1'h1);
    endtask
    task automatic t_refuse();
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, 4'h4, i ? 32'h0000_0040 : 32'h0000_0008);
            instr(1'b0);
            chk("refused", halt_n, 1'h1);
        end
        wb(1'b1, 4'h4, 32'h0000_0000);
    endtask
    task automatic t_sleep_on();
        int n;
        wb(1'b1, 4'h8, 32'h0000_0001);
        @(posedge clk_i) ei <= 1'b1;
        @(posedge clk_i) ei <= 1'b0;
        irq1_n <= 1'b0;
        instr(1'b0);
        chk("sleep", {halt_n, core_en, dma_en, rf_en, bus_high, per_en},
            6'h03);
        busack <= 1'b1;
        tick(3);
        chk("granted", bus_high, 1'h0);
        busack <= 1'b0;
        tick(9);
        chk("disabled src", halt_n, 1'h0);
        irq0_n <= 1'b0;
        wait_resume(n);
        chk("take", take, 1'h1);
        chk("ret", raddr, pc);
        {irq0_n, irq1_n} <= 2'b11;
        tick(6);
    endtask
    task automatic t_sleep_off();
        int n;
        wb(1'b1, 4'h8, 32'h0000_0090);
        @(posedge clk_i) di <= 1'b1;
        @(posedge clk_i) di <= 1'b0;
        instr(1'b0);
        oirq <= 1'b1;
        wait_resume(n);
        chk("no take", take, 1'h0);
        chk("wake time", n <= 4, 1'h1);
        oirq <= 1'b0;
        tick(2);
    endtask
    task automatic t_stop();
        int n;
        wb(1'b1, 4'h0, 32'h0000_0020);
        tick(2);
        chk("frozen", {per_en, core_en}, 2'h1);
        wb(1'b1, 4'h8, 32'h0000_0088);
        pirq <= 1'b1;
        instr(1'b0);
        wb(1'b0, 4'hC, 32'h0000_0000);
        chk("stop mode", q[4:0], 5'h08);
        tick(8);
        chk("frozen src", halt_n, 1'h0);
        nmi_n <= 1'b0;
        wait_resume(n);
        chk("nmi take", take, 1'h1);
        {nmi_n, pirq} <= 2'b10;
        wb(1'b1, 4'h0, 32'h0000_0000);
        tick(2);
        chk("restart", per_en, 1'h1);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, cyc, stb, we, hreq, sreq, ei, di} = 8'h80;
        {pirq, oirq, busack, nmi_n, irq0_n, irq1_n, irq2_n} = 7'h0F;
        adr = 4'h0;
        wdat = 32'h0000_0000;
        pc = 16'h1000;
        num_errors = 0;
        checks_done = 0;
        tick(4);
        rst_i <= 1'b0;
        tick(6);
        t_reset();
        t_halt();
        t_refuse();
        t_sleep_on();
        t_sleep_off();
        t_stop();
        give_verdict();
    end
    initial begin
        tick(5000);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
